// >>> rtl/hsc_top.sv
// Purpose: Hall six-step commutation controller with AHB-Lite registers.
// Assumes: hall_in and oc_cmp_in are asynchronous pins; vbus_in is an
//          ADC result already on mclk.
// Notes:   Zero-wait-state slave; every access answers OKAY.
// Contract
// - Three Hall levels decode into six sectors; 000 and 111 invalid.
// - Each sector drives exactly two phases, third phase off.
// - Applied voltage vector lies on a boundary of the Hall sector.
// - Vector from sector and direction; code 100 gives 2 CCW, 5 CW.
// - Direction is programmable; two tables serve CW and CCW.
// - Both high and low switch of the active pair chop with PWM.
// - Any Hall edge triggers a commutation that updates the pattern; code updates it only in RUN.
// - Commutation samples all three Hall levels to find the sector.
// - Commutation captures the free-running timer as timestamp.
// - A 1 kHz tick from PWM runs regulator, state machine, faults; code checks only over- and undervoltage on it.
// - New duty reaches the PWM generator only on the control tick.
// - Each tick computes rotor speed from cached commutation times.
// - Speed command is clamped between 300 and 2200 rpm.
// - Current limit resets to 4 A.
// - Overcurrent comparator disables outputs at once, no software.
// - Overvoltage, undervoltage, overcurrent are flagged; drive stops.
// - Start takes its first pattern from present sector, no alignment.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "hsc_defines.svh"

module hsc_top
  import hsc_pkg::*;
#(
  parameter int PWM_PERIOD = `HSC_PWM_CYC,
  parameter int TICK_PWM   = `HSC_TICK_PWM,
  parameter int POLE_PAIRS = `HSC_POLE_PAIRS
)(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Sensors and analog results
  input  wire logic [2:0]  hall_in,
  input  wire logic        oc_cmp_in,
  input  wire logic [11:0] vbus_in,
  // Inverter gates and current threshold to the DAC
  output hsc_gate_t        gate,
  output logic      [15:0] ilim_ma
);

  // The speed numerator must fit 32 bits, which rules out one pole pair
  if (PWM_PERIOD < 2 || PWM_PERIOD > 65535 || TICK_PWM < 1 ||
      POLE_PAIRS < 1 || 64'd60 * `HSC_CLK_HZ / POLE_PAIRS > 64'hFFFFFFFF)
  begin : g_chk
    $error("hsc_top: unsupported parameter value");
  end

  localparam logic [15:0] PER = 16'(PWM_PERIOD);
  localparam logic [31:0] RPM_NUM =
    32'((64'd60 * `HSC_CLK_HZ) / POLE_PAIRS);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Vector 1..6 from Hall code {A,B,C}; 0 means invalid code
  function automatic logic [2:0] vec_of(input logic [2:0] c,
                                        input logic cw);
    logic [2:0] v;
    v = 3'h0;
    case (c)
      3'b100: v = 3'h2;
      3'b110: v = 3'h3;
      3'b010: v = 3'h4;
      3'b011: v = 3'h5;
      3'b001: v = 3'h6;
      3'b101: v = 3'h1;
      default: v = 3'h0;
    endcase
    if (cw && v != 3'h0)
      v = (v > 3'h3) ? v - 3'h3 : v + 3'h3;
    return v;
  endfunction

  // One-hot phase that sources (hi) or sinks current for a vector
  function automatic logic [2:0] pole(input logic [2:0] v,
                                      input logic hi);
    logic [2:0] p;
    p = 3'h0;
    case (v)
      3'h1: p = hi ? 3'b001 : 3'b010;
      3'h2: p = hi ? 3'b001 : 3'b100;
      3'h3: p = hi ? 3'b010 : 3'b100;
      3'h4: p = hi ? 3'b010 : 3'b001;
      3'h5: p = hi ? 3'b100 : 3'b001;
      3'h6: p = hi ? 3'b100 : 3'b010;
      default: p = 3'h0;
    endcase
    return p;
  endfunction

  function automatic logic at(input logic [31:0] a, input logic [7:0] o);
    return a[7:0] == o && a[31:8] == 24'h0;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0]  hall_m_ff;
  logic [2:0]  hall_s_ff;
  logic [2:0]  hall_p_ff;
  logic        oc_m_ff;
  logic        oc_s_ff;

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      hall_m_ff <= 3'h0;
      hall_s_ff <= 3'h0;
      hall_p_ff <= 3'h0;
      oc_m_ff   <= 1'b0;
      oc_s_ff   <= 1'b0;
    end
    else if (clk_en)
    begin
      hall_m_ff <= hall_in;
      hall_s_ff <= hall_m_ff;
      hall_p_ff <= hall_s_ff;
      oc_m_ff   <= oc_cmp_in;
      oc_s_ff   <= oc_m_ff;
    end

  logic commute;
  assign commute = hall_s_ff != hall_p_ff;

  // ****************************************************************
  // PWM counter and control tick
  // ****************************************************************
  logic [15:0] pcnt_ff;
  logic [15:0] tdiv_ff;
  logic [15:0] cmp_ff;
  logic        tick;
  logic        wrap;

  assign wrap = pcnt_ff == PER - 16'h1;
  assign tick = wrap && tdiv_ff == 16'(TICK_PWM - 1);

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      pcnt_ff <= 16'h0;
      tdiv_ff <= 16'h0;
    end
    else if (clk_en)
    begin
      pcnt_ff <= wrap ? 16'h0 : pcnt_ff + 16'h1;
      if (wrap)
        tdiv_ff <= tick ? 16'h0 : tdiv_ff + 16'h1;
    end

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************
  logic        run_ff;
  logic        dir_ff;
  logic [15:0] spd_cmd_ff;
  logic [11:0] ov_ff;
  logic [11:0] uv_ff;
  logic        wr_ff;
  logic [31:0] wa_ff;
  logic        addr_ok;
  logic        wen;
  logic [15:0] wlo;

  assign addr_ok = hsel && htrans[1] && hready;
  assign wen     = wr_ff;
  assign wlo     = hwdata[15:0];

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      wr_ff <= 1'b0;
      wa_ff <= 32'h0;
    end
    else if (clk_en)
    begin
      wr_ff <= addr_ok && hwrite;
      if (addr_ok)
        wa_ff <= haddr;
    end

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      run_ff     <= 1'b0;
      dir_ff     <= 1'b0;
      spd_cmd_ff <= `HSC_SPD_MIN;
      ilim_ma    <= `HSC_ILIM_RST;
      ov_ff      <= `HSC_OV_RST;
      uv_ff      <= `HSC_UV_RST;
    end
    else if (clk_en && wen)
    begin
      if (at(wa_ff, `HSC_A_CTRL))
      begin
        run_ff <= hwdata[`HSC_B_RUN];
        dir_ff <= hwdata[`HSC_B_DIR];
      end
      if (at(wa_ff, `HSC_A_SPDCMD))
        spd_cmd_ff <= wlo < `HSC_SPD_MIN ? `HSC_SPD_MIN :
                      wlo > `HSC_SPD_MAX ? `HSC_SPD_MAX : wlo;
      if (at(wa_ff, `HSC_A_ILIM))
        ilim_ma <= wlo;
      if (at(wa_ff, `HSC_A_VLIM))
      begin
        ov_ff <= hwdata[`HSC_B_OV_LO +: 12];
        uv_ff <= hwdata[11:0];
      end
    end

  // ****************************************************************
  // Faults: hardware sets win over a write-one-to-clear
  // ****************************************************************
  hsc_fault_t  flt_ff;
  hsc_fault_t  flt_set;
  hsc_fault_t  flt_clr;
  hsc_state_t  st_ff;
  logic [2:0]  vec_ff;
  logic        start;

  assign start = tick && st_ff == HSC_IDLE && run_ff && flt_ff == '0;

  always_comb
  begin
    flt_set      = '0;
    flt_set.oc   = oc_s_ff;
    flt_set.ov   = tick && vbus_in > ov_ff;
    flt_set.uv   = tick && vbus_in < uv_ff;
    flt_set.hall = (commute || start) && st_ff != HSC_FAULT &&
                   vec_of(hall_s_ff, dir_ff) == 3'h0;
    flt_clr      = (wen && at(wa_ff, `HSC_A_STATUS)) ?
                   hsc_fault_t'(hwdata[3:0]) : '0;
  end

  always_ff @(posedge mclk)
    if (!rstn)
      flt_ff <= '0;
    else if (clk_en)
      flt_ff <= (flt_ff & ~flt_clr) | flt_set;

  // ****************************************************************
  // Run state machine, advanced on the control tick
  // ****************************************************************
  always_ff @(posedge mclk)
    if (!rstn)
      st_ff <= HSC_IDLE;
    else if (clk_en && tick)
      case (st_ff)
        HSC_IDLE:
          if (start)
            st_ff <= HSC_RUN;
        HSC_RUN:
          if (flt_ff != '0 || flt_set != '0)
            st_ff <= HSC_FAULT;
          else if (!run_ff)
            st_ff <= HSC_IDLE;
        HSC_FAULT:
          if (!run_ff && flt_ff == '0)
            st_ff <= HSC_IDLE;
        default:
          st_ff <= HSC_IDLE;
      endcase

  // ****************************************************************
  // Commutation, timestamps and sector durations
  // ****************************************************************
  logic [31:0] timer_ff;
  logic [31:0] ts_ff;
  logic [31:0] dur_ff [`HSC_SECTORS];
  logic [2:0]  ptr_ff;
  logic [2:0]  fill_ff;

  always_ff @(posedge mclk)
    if (!rstn)
      vec_ff <= 3'h0;
    else if (clk_en)
    begin
      if (start || (st_ff == HSC_RUN && commute))
        vec_ff <= vec_of(hall_s_ff, dir_ff);
      else if (st_ff != HSC_RUN && !start)
        vec_ff <= 3'h0;
    end

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      timer_ff <= 32'h0;
      ts_ff    <= 32'h0;
      ptr_ff   <= 3'h0;
      fill_ff  <= 3'h0;
      for (int i = 0; i < `HSC_SECTORS; i++)
        dur_ff[i] <= 32'h0;
    end
    else if (clk_en)
    begin
      timer_ff <= timer_ff + 32'h1;
      if (commute)
      begin
        ts_ff          <= timer_ff;
        dur_ff[ptr_ff] <= timer_ff - ts_ff;
        ptr_ff <= ptr_ff == 3'(`HSC_SECTORS - 1) ? 3'h0 : ptr_ff + 3'h1;
        if (fill_ff != 3'(`HSC_SECTORS))
          fill_ff <= fill_ff + 3'h1;
      end
      if (st_ff != HSC_RUN)
        fill_ff <= 3'h0;
    end

  // ****************************************************************
  // Speed measurement and regulator
  // ****************************************************************
  logic [34:0] six_sum;
  logic [31:0] rpm_q;
  logic [15:0] speed_ff;
  logic [15:0] duty_ff;

  // Six sectors make one electrical turn, so jitter between sensors
  // cancels out of the sum.
  always_comb
  begin
    six_sum = 35'h0;
    for (int i = 0; i < `HSC_SECTORS; i++)
      six_sum = six_sum + 35'(dur_ff[i]);
    rpm_q = (six_sum == 35'h0 || six_sum[34:32] != 3'h0) ? 32'h0 :
            RPM_NUM / six_sum[31:0];
  end

  always_ff @(posedge mclk)
    if (!rstn)
    begin
      speed_ff <= 16'h0;
      duty_ff  <= 16'h0;
      cmp_ff   <= 16'h0;
    end
    else if (clk_en && tick)
    begin
      speed_ff <= fill_ff != 3'(`HSC_SECTORS) ? 16'h0 :
                  rpm_q[31:16] != 16'h0 ? 16'hFFFF : rpm_q[15:0];
      if (st_ff != HSC_RUN)
        duty_ff <= 16'h0;
      else if (speed_ff < spd_cmd_ff)
        duty_ff <= (PER - duty_ff > `HSC_DUTY_STEP) ?
                   duty_ff + `HSC_DUTY_STEP : PER;
      else if (speed_ff > spd_cmd_ff)
        duty_ff <= duty_ff > `HSC_DUTY_STEP ?
                   duty_ff - `HSC_DUTY_STEP : 16'h0;
      cmp_ff <= duty_ff;
    end

  // ****************************************************************
  // Gate drive: comparator trip bypasses every software path
  // ****************************************************************
  logic pwm_on;
  logic drive;

  assign pwm_on = pcnt_ff < cmp_ff;
  assign drive  = st_ff == HSC_RUN && !oc_s_ff && !flt_ff.oc;

  always_ff @(posedge mclk)
    if (!rstn)
      gate <= '0;
    else if (clk_en)
    begin
      gate.hi <= (drive && pwm_on) ? pole(vec_ff, 1'b1) : 3'h0;
      gate.lo <= (drive && pwm_on) ? pole(vec_ff, 1'b0) : 3'h0;
    end

  // ****************************************************************
  // Read data, registered for the data phase
  // ****************************************************************
  always_ff @(posedge mclk)
    if (!rstn)
    begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (clk_en)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      if (addr_ok && !hwrite)
      begin
        if (at(haddr, `HSC_A_CTRL))
          hrdata <= {30'h0, dir_ff, run_ff};
        if (at(haddr, `HSC_A_SPDCMD))
          hrdata <= {16'h0, spd_cmd_ff};
        if (at(haddr, `HSC_A_ILIM))
          hrdata <= {16'h0, ilim_ma};
        if (at(haddr, `HSC_A_VLIM))
          hrdata <= {4'h0, ov_ff, 4'h0, uv_ff};
        if (at(haddr, `HSC_A_STATUS))
          hrdata <= {19'h0, vec_ff, st_ff, 1'b0,
                     hall_s_ff, flt_ff};
        if (at(haddr, `HSC_A_SPEED))
          hrdata <= {16'h0, speed_ff};
        if (at(haddr, `HSC_A_TSTAMP))
          hrdata <= ts_ff;
        if (at(haddr, `HSC_A_DUTY))
          hrdata <= {16'h0, cmp_ff};
      end
    end

endmodule

// >>> rtl/hsc_defines.svh
// Purpose: Constants of the Hall six-step commutation controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Offsets are byte addresses on the AHB-Lite register bus.
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

// Clock, PWM and control-tick rates in hertz
`define HSC_CLK_HZ    100000000
`define HSC_PWM_HZ    20000
`define HSC_TICK_HZ   1000
`define HSC_PWM_CYC   (`HSC_CLK_HZ / `HSC_PWM_HZ)
`define HSC_TICK_PWM  (`HSC_PWM_HZ / `HSC_TICK_HZ)
`define HSC_POLE_PAIRS 2
`define HSC_SECTORS   6

// Register byte offsets
`define HSC_A_CTRL    8'h00
`define HSC_A_SPDCMD  8'h04
`define HSC_A_ILIM    8'h08
`define HSC_A_VLIM    8'h0C
`define HSC_A_STATUS  8'h10
`define HSC_A_SPEED   8'h14
`define HSC_A_TSTAMP  8'h18
`define HSC_A_DUTY    8'h1C

// Field positions
`define HSC_B_RUN     0
`define HSC_B_DIR     1
`define HSC_B_OV_LO   16

// Reset values and limits
`define HSC_SPD_MIN   16'h012C
`define HSC_SPD_MAX   16'h0898
`define HSC_ILIM_RST  16'h0FA0
`define HSC_OV_RST    12'hE00
`define HSC_UV_RST    12'h200
`define HSC_DUTY_STEP 16'h0005

`endif

// >>> rtl/hsc_pkg.sv
// Purpose: Types of the Hall six-step commutation controller.
// Assumes: Constants live in hsc_defines.svh.
// Notes:   Gate drive and fault flags travel as packed structs.
package hsc_pkg;

  typedef enum logic [1:0] {HSC_IDLE, HSC_RUN, HSC_FAULT} hsc_state_t;

  // High and low switch of phases C,B,A (bit 0 is phase A)
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } hsc_gate_t;

  typedef struct packed {
    logic hall;
    logic uv;
    logic ov;
    logic oc;
  } hsc_fault_t;

endpackage

// >>> dv/hsc_assertions.sv
// Purpose: Port assertions for hsc_top.
// Assumes: clk_en is high whenever reset is applied.
// Notes:   Direction is not visible here; tables are checked in tb.
`timescale 1ns/1ns
module hsc_assertions
  import hsc_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        clk_en,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  // Motor side
  input wire logic [2:0]  hall_in,
  input wire logic        oc_cmp_in,
  input wire hsc_gate_t   gate,
  input wire logic [15:0] ilim_ma
);
  logic       wr_seen;
  logic [2:0] oc_run_ff;
  logic       oc_hold_ff;

  assign wr_seen = hsel && htrans[1] && hwrite && hready;

  always_ff @(posedge mclk)
  begin
    if (!rstn || !oc_cmp_in)
      oc_run_ff <= 3'h0;
    else if (oc_run_ff != 3'h6)
      oc_run_ff <= oc_run_ff + 3'h1;
  end

  // A latched overcurrent keeps the bridge off until software writes
  always_ff @(posedge mclk)
  begin
    if (!rstn || wr_seen)
      oc_hold_ff <= 1'b0;
    else if (oc_run_ff == 3'h6)
      oc_hold_ff <= 1'b1;
  end

  default clocking cb @(posedge mclk);
  endclocking

  a_one_per_side: assert property (disable iff (!rstn)
    $onehot0(gate.hi) && $onehot0(gate.lo))
    else $error("more than one switch on per side");
  a_pair_distinct: assert property (disable iff (!rstn)
    (gate.hi & gate.lo) == 3'h0)
    else $error("both switches of one phase on");
  a_chop_both: assert property (disable iff (!rstn)
    (gate.hi != 3'h0) == (gate.lo != 3'h0))
    else $error("only one side of the pair chopped");
  a_oc_cuts_gate: assert property (disable iff (!rstn)
    oc_cmp_in [*6] |-> gate == 6'h0)
    else $error("gates on during overcurrent");
  a_fault_holds_off: assert property (disable iff (!rstn)
    oc_hold_ff |-> gate == 6'h0)
    else $error("gates on before fault was cleared");
  a_bad_hall_off: assert property (disable iff (!rstn)
    (hall_in == 3'h0 || hall_in == 3'h7) [*7] |-> gate == 6'h0)
    else $error("gates on with invalid hall code");
  a_reset_values: assert property (disable iff (1'b0)
    !rstn && clk_en |=> gate == 6'h0 && ilim_ma == 16'h0FA0)
    else $error("reset values wrong");
  a_ilim_by_write: assert property (disable iff (!rstn)
    $changed(ilim_ma) && $past(rstn) |-> $past(wr_seen, 2))
    else $error("current limit moved without a write");
endmodule

bind hsc_top hsc_assertions u_chk (.mclk(mclk), .rstn(rstn),
  .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hall_in(hall_in), .oc_cmp_in(oc_cmp_in),
  .gate(gate), .ilim_ma(ilim_ma));

// >>> dv/hsc_motor_model.sv
// Purpose: Hall sensors and inverter sense lines facing hsc_top.
// Assumes: Rotor parked mid-sector; the bench steps the sector.
// Notes:   bad forces 000 or 111 to break the sensor side on purpose.
`timescale 1ns/1ns
module hsc_motor_model
(
  // Bench controls
  input  wire logic [2:0]  sector,
  input  wire logic [1:0]  bad,
  input  wire logic        oc_req,
  input  wire logic [11:0] vbus_req,
  // Controller pins
  output logic      [2:0]  hall_in,
  output logic             oc_cmp_in,
  output logic      [11:0] vbus_in
);
  int ang;

  // High over the half turn ahead of the phase axis
  function automatic logic seen(input int a, input int axis);
    return ((a - axis + 360) % 360) < 180;
  endfunction

  always_comb
  begin
    ang = sector * 60 + 30;
    hall_in = {seen(ang, 0), seen(ang, 120), seen(ang, 240)};
    if (bad == 2'h1)
      hall_in = 3'h0;
    else if (bad == 2'h2)
      hall_in = 3'h7;
    oc_cmp_in = oc_req;
    vbus_in = vbus_req;
  end
endmodule

// >>> dv/tb.sv
// Purpose: Self-checking bench for hsc_top.
// Assumes: Short PWM period and tick keep the run to a few thousand cycles.
// Notes:   Direction shows only through STATUS and the gate pattern.
`timescale 1ns/1ns
`include "hsc_defines.svh"
module tb
  import hsc_pkg::*;
;
  localparam int PER  = 20;
  localparam int TICK = PER * 2;
  // Phase of the high and low switch for vectors 1..6
  localparam int HP[7] = '{0, 0, 0, 1, 1, 2, 2};
  localparam int LP[7] = '{0, 1, 2, 2, 0, 0, 1};
  localparam logic [2:0] CODE[6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

  logic        mclk, rstn, hsel, hwrite, hreadyout, hresp;
  logic        oc_req, oc_cmp_in;
  logic [1:0]  htrans, bad;
  logic [2:0]  sector, hall_in;
  logic [11:0] vbus_req, vbus_in;
  logic [15:0] ilim_ma;
  logic [31:0] haddr, hwdata, hrdata, rd, d0;
  hsc_gate_t   gate;
  int          failures, n_checks;

  hsc_top #(.PWM_PERIOD(PER), .TICK_PWM(2), .POLE_PAIRS(2)) u_dut (
    .mclk(mclk), .rstn(rstn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .hall_in(hall_in), .oc_cmp_in(oc_cmp_in),
    .vbus_in(vbus_in), .gate(gate), .ilim_ma(ilim_ma));

  hsc_motor_model u_motor (.sector(sector), .bad(bad), .oc_req(oc_req),
    .vbus_req(vbus_req), .hall_in(hall_in), .oc_cmp_in(oc_cmp_in),
    .vbus_in(vbus_in));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****
  // Tasks
  // ****
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Bounded wait so a stuck slave cannot hang the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      close_out();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // Any sample with a gate on must show exactly the expected pair
  task automatic gate_chk(input int v, input logic need_on);
    int        on;
    hsc_gate_t g;
    on = 0;
    g.hi = (v == 0) ? 3'h0 : 3'h1 << HP[v];
    g.lo = (v == 0) ? 3'h0 : 3'h1 << LP[v];
    repeat (PER)
    begin
      @(posedge mclk);
      if (gate !== 6'h0)
      begin
        chk(32'(gate), 32'(g));
        on++;
      end
    end
    if (need_on)
      chk(32'(on != 0), 32'(v != 0));
  endtask

  task automatic step(input int s, input int cw);
    logic [31:0] t0;
    int          v;
    v = cw ? (s + 3) % 6 + 1 : s + 1;
    bus(1'b0, `HSC_A_TSTAMP, 32'h0);
    t0 = rd;
    sector <= 3'(s);
    cyc(12);
    bus(1'b0, `HSC_A_STATUS, 32'h0);
    chk(32'({rd[12:8], rd[6:0]}), 32'({v[2:0], 2'h1, CODE[s], 4'h0}));
    bus(1'b0, `HSC_A_TSTAMP, 32'h0);
    chk(32'(rd != t0), 32'h1);
    gate_chk(v, cw == 0);
  endtask

  task automatic fault_case(input int k);
    bus(1'b1, `HSC_A_CTRL, 32'h0);
    bus(1'b1, `HSC_A_STATUS, 32'hF);
    cyc(2 * TICK);
    bus(1'b1, `HSC_A_CTRL, 32'h1);
    cyc(3 * TICK);
    oc_req   <= (k == 0);
    vbus_req <= k == 1 ? 12'hF00 : k == 2 ? 12'h100 : 12'h800;
    bad      <= k > 2 ? 2'(k - 2) : 2'h0;
    cyc(3 * TICK);
    bus(1'b0, `HSC_A_STATUS, 32'h0);
    chk(32'(rd[k > 2 ? 3 : k]), 32'h1);
    if (k < 3)
      chk(32'(rd[9:8]), 32'h2);
    else
      chk(32'(rd[12:10]), 32'h0);
    gate_chk(0, 1'b1);
    oc_req   <= 1'b0;
    vbus_req <= 12'h800;
    bad      <= 2'h0;
  endtask

  initial
  begin
    failures = 0;
    n_checks = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sector = 3'h0;
    bad = 2'h0;
    oc_req = 1'b0;
    vbus_req = 12'h800;
    cyc(10);
    rstn <= 1'b1;
    bus(1'b0, `HSC_A_ILIM, 32'h0);
    chk(rd, 32'h0FA0);
    chk(32'(ilim_ma), 32'h0FA0);
    chk(32'({hreadyout, hresp}), 32'h2);
    bus(1'b0, `HSC_A_VLIM, 32'h0);
    chk(rd, {4'h0, `HSC_OV_RST, 4'h0, `HSC_UV_RST});
    bus(1'b1, `HSC_A_VLIM, 32'h0D000300);
    bus(1'b0, `HSC_A_VLIM, 32'h0);
    chk(rd, 32'h0D000300);
    bus(1'b0, `HSC_A_SPDCMD, 32'h0);
    chk(rd, 32'h012C);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `HSC_A_SPDCMD, 32'h64);
    bus(1'b0, `HSC_A_SPDCMD, 32'h0);
    chk(rd, 32'h012C);
    bus(1'b1, `HSC_A_SPDCMD, 32'h1388);
    bus(1'b0, `HSC_A_SPDCMD, 32'h0);
    chk(rd, 32'h0898);
    bus(1'b1, `HSC_A_ILIM, 32'h1388);
    bus(1'b0, `HSC_A_ILIM, 32'h0);
    chk(32'(ilim_ma), 32'h1388);
    bus(1'b1, `HSC_A_CTRL, 32'h1);
    cyc(3 * TICK);
    bus(1'b0, `HSC_A_STATUS, 32'h0);
    chk(32'(rd[12:8]), 32'h5);
    bus(1'b0, `HSC_A_DUTY, 32'h0);
    d0 = rd;
    cyc(TICK);
    bus(1'b0, `HSC_A_DUTY, 32'h0);
    chk(32'(rd != d0), 32'h1);
    for (int c = 0; c < 2; c++)
    begin
      bus(1'b1, `HSC_A_CTRL, {30'h0, c[0], 1'b1});
      for (int s = 1; s <= 6; s++)
        step(s % 6, c);
    end
    cyc(2 * TICK);
    bus(1'b0, `HSC_A_SPEED, 32'h0);
    chk(32'(rd != 32'h0), 32'h1);
    for (int k = 0; k < 5; k++)
      fault_case(k);
    // Second reset in mid-run must restore the reset-value limits
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    bus(1'b0, `HSC_A_ILIM, 32'h0);
    chk(rd, 32'(`HSC_ILIM_RST));
    chk(32'(ilim_ma), 32'(`HSC_ILIM_RST));
    bus(1'b0, `HSC_A_VLIM, 32'h0);
    chk(rd, {4'h0, `HSC_OV_RST, 4'h0, `HSC_UV_RST});
    close_out();
  end

  initial
  begin
    repeat (50000) @(posedge mclk);
    failures++;
    close_out();
  end
endmodule
